// ### host_ctrl_model.sv
// host controller model driving the absolute data request pin
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model #(
    parameter realtime DLY = 7.3
) (
    input  wire logic req_en,
    output logic      abs_data_request
);
    // pin follows the host's wish after its own delay, unrelated to the core clock
    initial abs_data_request = 1'b0;
    always @(req_en) abs_data_request <= #(DLY) req_en;
endmodule
`default_nettype wire

// ### servo_status_consts.svh
// offsets, field positions, reset values and limits of the servo status outputs
`ifndef SERVO_STATUS_CONSTS_SVH
`define SERVO_STATUS_CONSTS_SVH
// register word offsets (byte addresses)
`define ADDR_ROT_LEVEL      8'h00
`define ADDR_APPROACH_W     8'h04
`define ADDR_OSEL1          8'h08
`define ADDR_OSEL2          8'h0C
`define ADDR_OSEL3          8'h10
`define ADDR_CONFIG         8'h14
`define ADDR_STATUS         8'h18
`define ADDR_INT_STATUS     8'h1C
`define ADDR_INT_MASK       8'h20
`define ADDR_MONITOR        8'h24
// widths of the settings
`define ROT_W               14
`define APPR_W              8
`define OSEL_W              16
`define ALLOC_W             4
// rotation detection level range and reset value, rpm
`define ROT_MIN             14'h0001
`define ROT_MAX             14'h2710
`define ROT_RST             14'h0014
// approach width range and reset value, reference units
`define APPR_MIN            8'h01
`define APPR_MAX            8'hFA
`define APPR_RST            8'h07
// output selection reset values
`define OSEL1_RST           16'h3211
`define OSEL2_RST           16'h0000
`define OSEL3_RST           16'h0000
// allocation field positions
`define RUN_ALLOC_LSB       8
`define READY_ALLOC_LSB     12
`define CAUTION_ALLOC_LSB   12
`define APPROACH_ALLOC_LSB  0
// config bit positions
`define CFG_WCODE_BIT       0
`define CFG_ABS_BIT         1
// number of output circuits
`define NUM_CIRCUITS        3
`endif

// ### servo_status_monitor.sv
// checker for the servo status outputs
`timescale 1ns/10ps
`default_nettype none
module servo_status_monitor #(
    parameter int SPEED_W = 16
) (
    input wire logic                      core_clk,
    input wire logic                      sys_rst,
    input wire logic signed [SPEED_W-1:0] motor_speed,
    input wire logic                      position_mode,
    input wire logic                      servo_alarm,
    input wire logic [2:0]                alarm_code,
    input wire logic                      overload_warn,
    input wire logic                      regen_warn,
    input wire logic [2:0]                circuit_n,
    input wire logic                      alarm_code_line1,
    input wire logic                      alarm_code_line2,
    input wire logic                      alarm_code_line3,
    input wire logic                      running_monitor_item,
    input wire logic                      status_running,
    input wire logic                      irq
);
    //////////////////////////////
    // code lines as one word, warning summary
    wire [2:0] code   = {alarm_code_line3, alarm_code_line2, alarm_code_line1};
    wire       nowarn = !overload_warn && !regen_warn;
    wire       fast   = motor_speed > 10000 || motor_speed < -10000;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // circuits, code lines and irq inactive straight after reset
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> circuit_n == 3'h7 && code == 3'h7 && !irq)
        else $error("outputs not idle after reset");
    a_alarm_code: assert property ((servo_alarm && $stable(alarm_code))[*3] |-> code == ~alarm_code)
        else $error("alarm code not shown");
    a_quiet_code: assert property ((!servo_alarm && nowarn)[*3] |-> code == 3'h7)
        else $error("code lines active without cause");
    a_overload_code: assert property ((!servo_alarm && overload_warn)[*3] |-> code[2:1] == 2'h3)
        else $error("overload code wrong");
    a_regen_code: assert property ((!servo_alarm && regen_warn && !overload_warn)[*3] |-> code[2] && code[0])
        else $error("regen code wrong");
    a_fast_runs: assert property (fast[*3] |-> status_running)
        else $error("running missed");
    a_still_idle: assert property ((motor_speed == 0)[*3] |-> !status_running)
        else $error("running while still");
    a_monitor_mirror: assert property (status_running == running_monitor_item)
        else $error("monitor differs from status");
    a_idle_circuits: assert property ((servo_alarm && nowarn && !position_mode && motor_speed == 0)[*3]
        |-> circuit_n == 3'h7)
        else $error("circuit active with no flag");

    // main scenarios reached
    c_circuit_on: cover property (circuit_n != 3'h7);
    c_irq_rise: cover property (!irq ##1 irq);
    c_warn_code: cover property (!servo_alarm && code != 3'h7);
endmodule
//////////////////////////////
bind servo_status_outputs servo_status_monitor #(.SPEED_W(SPEED_W)) mon (
    .core_clk(core_clk), .sys_rst(sys_rst), .motor_speed(motor_speed), .position_mode(position_mode),
    .servo_alarm(servo_alarm), .alarm_code(alarm_code), .overload_warn(overload_warn), .regen_warn(regen_warn),
    .circuit_n(circuit_n), .alarm_code_line1(alarm_code_line1), .alarm_code_line2(alarm_code_line2),
    .alarm_code_line3(alarm_code_line3), .running_monitor_item(running_monitor_item),
    .status_running(status_running), .irq(irq));
`default_nettype wire

// ### servo_status_outputs.sv
// servo drive sequence status outputs: running, ready, caution, approach and warning code lines
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "servo_status_consts.svh"

module servo_status_outputs
    import servo_status_pkg::*;
#(
    parameter int SPEED_W = 16,
    parameter int ERR_W   = 32
) (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    // register port
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    // drive state from the control loops, same clock
    input  wire logic signed [SPEED_W-1:0] motor_speed,
    input  wire logic signed [ERR_W-1:0]  position_error,
    input  wire logic                     position_mode,
    input  wire logic                     servo_alarm,
    input  wire logic [2:0]               alarm_code,
    input  wire logic                     main_power_on,
    input  wire logic                     overload_warn,
    input  wire logic                     regen_warn,
    input  wire logic                     abs_transfer_done,
    // pin from the host, asynchronous
    input  wire logic                     abs_data_request,
    // status outputs: circuits and code lines active low, running, monitor item and irq active high
    output logic [`NUM_CIRCUITS-1:0]      circuit_n,
    output logic                          alarm_code_line1,
    output logic                          alarm_code_line2,
    output logic                          alarm_code_line3,
    output logic                          running_monitor_item,
    output logic                          status_running,
    output logic                          irq
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // magnitudes are compared at the error width, so it must hold speed and settings
    if (ERR_W < SPEED_W || ERR_W < `ROT_W || SPEED_W < 2) begin : g_bad_width
        $error("servo_status_outputs: ERR_W must cover SPEED_W and the setting widths");
    end

    // allocation fields must be able to name every circuit
    if ((1 << `ALLOC_W) <= `NUM_CIRCUITS) begin : g_bad_alloc
        $error("servo_status_outputs: allocation field too narrow for the circuits");
    end

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // magnitude of a signed value at error width
    function automatic logic [ERR_W-1:0] mag(input logic signed [ERR_W-1:0] v);
        logic [ERR_W-1:0] r;
        // the most negative value wraps to itself, read as unsigned
        r = v[ERR_W-1] ? ERR_W'(-v) : ERR_W'(v);
        return r;
    endfunction

    // keep a written setting inside its legal range
    function automatic logic [15:0] clamp(
        input logic [15:0] v,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        logic [15:0] r;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end else begin
            r = v;
        end
        return r;
    endfunction

    // OR every flag onto the circuit its allocation field names; 0 or above 3 routes nowhere
    function automatic logic [`NUM_CIRCUITS-1:0] route(
        input flags_s             f,
        input logic [`ALLOC_W-1:0] a_run,
        input logic [`ALLOC_W-1:0] a_ready,
        input logic [`ALLOC_W-1:0] a_caution,
        input logic [`ALLOC_W-1:0] a_approach
    );
        logic [`NUM_CIRCUITS-1:0] r;
        r = '0;
        // circuit c answers to allocation value c + 1
        for (int c = 0; c < `NUM_CIRCUITS; c++) begin
            if (a_run == `ALLOC_W'(c + 1)) begin
                r[c] = r[c] | f.running;
            end
            if (a_ready == `ALLOC_W'(c + 1)) begin
                r[c] = r[c] | f.ready;
            end
            if (a_caution == `ALLOC_W'(c + 1)) begin
                r[c] = r[c] | f.caution;
            end
            if (a_approach == `ALLOC_W'(c + 1)) begin
                r[c] = r[c] | f.approach;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    localparam state_s ST_RST = '{
        // settings
        rot_level:   `ROT_RST,
        approach_w:  `APPR_RST,
        osel1:       `OSEL1_RST,
        osel2:       `OSEL2_RST,
        osel3:       `OSEL3_RST,
        wcode_sel:   1'b0,
        abs_use:     1'b0,
        // interrupt state
        int_status:  '0,
        int_mask:    '0,
        // pin synchroniser
        req_sync:    3'h0,
        req_filt:    1'b0,
        // registered flags and outputs, all inactive
        flags:       '0,
        circuit_n:   '1,
        code_n:      3'h7,
        running_mon: 1'b0,
        status_run:  1'b0,
        irq:         1'b0,
        // read data
        rdata:       32'h0
    };

    // whole block state and its next value
    state_s st_ff;
    state_s nxt_st;

    // comparison and decode helpers
    logic [ERR_W-1:0]  speed_mag;
    logic [ERR_W-1:0]  err_mag;
    logic [ERR_W-1:0]  rot_ext;
    logic [ERR_W-1:0]  appr_ext;
    flags_s            new_flags;
    flags_s            rise;
    flags_s            w1c;
    logic [2:0]        code_on;

    always_comb begin
        speed_mag = mag(ERR_W'(motor_speed));
        err_mag   = mag(position_error);
        rot_ext   = ERR_W'(st_ff.rot_level);
        appr_ext  = ERR_W'(st_ff.approach_w);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        nxt_st = st_ff;
        w1c    = '0;

        // register writes, settings clamped to their ranges
        if (reg_wr) begin
            case (reg_addr)
                // rotation detection level, rpm
                `ADDR_ROT_LEVEL: begin
                    nxt_st.rot_level = `ROT_W'(clamp(16'(reg_wdata[`ROT_W-1:0]),
                                                     16'(`ROT_MIN), 16'(`ROT_MAX)));
                end

                // approach width, reference units
                `ADDR_APPROACH_W: begin
                    nxt_st.approach_w = `APPR_W'(clamp(16'(reg_wdata[`APPR_W-1:0]),
                                                       16'(`APPR_MIN), 16'(`APPR_MAX)));
                end

                // running and ready allocation
                `ADDR_OSEL1: begin
                    nxt_st.osel1 = reg_wdata[`OSEL_W-1:0];
                end

                // caution allocation
                `ADDR_OSEL2: begin
                    nxt_st.osel2 = reg_wdata[`OSEL_W-1:0];
                end

                // approach allocation
                `ADDR_OSEL3: begin
                    nxt_st.osel3 = reg_wdata[`OSEL_W-1:0];
                end

                // warning code select, absolute encoder in use
                `ADDR_CONFIG: begin
                    nxt_st.wcode_sel = reg_wdata[`CFG_WCODE_BIT];
                    nxt_st.abs_use   = reg_wdata[`CFG_ABS_BIT];
                end

                // write one to clear an event
                `ADDR_INT_STATUS: begin
                    w1c = flags_s'(reg_wdata[3:0]);
                end

                // interrupt enable per flag
                `ADDR_INT_MASK: begin
                    nxt_st.int_mask = flags_s'(reg_wdata[3:0]);
                end

                // status, monitor and unmapped words ignore writes
                default: begin
                end
            endcase
        end

        // data request pin: three stages, taken once the last two agree
        nxt_st.req_sync = {st_ff.req_sync[1:0], abs_data_request};
        if (st_ff.req_sync[1] == st_ff.req_sync[2]) begin
            nxt_st.req_filt = st_ff.req_sync[2];
        end

        // flag evaluation, once per cycle
        new_flags.running = speed_mag > rot_ext;
        new_flags.ready   = !servo_alarm && main_power_on &&
                            (!st_ff.abs_use || (st_ff.req_filt && abs_transfer_done));
        new_flags.caution = overload_warn || regen_warn;
        new_flags.approach = position_mode && (err_mag < appr_ext);
        nxt_st.flags = new_flags;

        // circuits are driven low for an active flag
        nxt_st.circuit_n = ~route(new_flags,
                                  st_ff.osel1[`RUN_ALLOC_LSB +: `ALLOC_W],
                                  st_ff.osel1[`READY_ALLOC_LSB +: `ALLOC_W],
                                  st_ff.osel2[`CAUTION_ALLOC_LSB +: `ALLOC_W],
                                  st_ff.osel3[`APPROACH_ALLOC_LSB +: `ALLOC_W]);

        // code lines: alarm code first, warning code only when selected
        code_on = 3'h0;
        if (servo_alarm) begin
            code_on = alarm_code;
        end else if (st_ff.wcode_sel) begin
            if (overload_warn) begin
                code_on = 3'h1;
            end else if (regen_warn) begin
                code_on = 3'h2;
            end
        end
        nxt_st.code_n = ~code_on;

        // running indication and monitor item
        nxt_st.running_mon = new_flags.running;
        nxt_st.status_run  = new_flags.running;

        // sticky events on rising flags; a new event beats a clear in the same cycle
        rise = new_flags & ~st_ff.flags;
        nxt_st.int_status = (st_ff.int_status & ~w1c) | rise;
        // interrupt level follows the new status and mask
        nxt_st.irq = |(nxt_st.int_status & nxt_st.int_mask);

        // read data, valid in the cycle after the strobe only
        nxt_st.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                // rotation detection level
                `ADDR_ROT_LEVEL: begin
                    nxt_st.rdata = 32'(st_ff.rot_level);
                end

                // approach width
                `ADDR_APPROACH_W: begin
                    nxt_st.rdata = 32'(st_ff.approach_w);
                end

                // output select 1, all sixteen bits
                `ADDR_OSEL1: begin
                    nxt_st.rdata = 32'(st_ff.osel1);
                end

                // output select 2
                `ADDR_OSEL2: begin
                    nxt_st.rdata = 32'(st_ff.osel2);
                end

                // output select 3
                `ADDR_OSEL3: begin
                    nxt_st.rdata = 32'(st_ff.osel3);
                end

                // configuration bits
                `ADDR_CONFIG: begin
                    nxt_st.rdata = 32'({st_ff.abs_use, st_ff.wcode_sel});
                end

                // synchronised request and live flags
                `ADDR_STATUS: begin
                    nxt_st.rdata = 32'({st_ff.req_filt, st_ff.flags});
                end

                // sticky events
                `ADDR_INT_STATUS: begin
                    nxt_st.rdata = 32'(st_ff.int_status);
                end

                // interrupt enables
                `ADDR_INT_MASK: begin
                    nxt_st.rdata = 32'(st_ff.int_mask);
                end

                // running monitor item
                `ADDR_MONITOR: begin
                    nxt_st.rdata = 32'(st_ff.running_mon);
                end

                // unmapped words read as zero
                default: begin
                    nxt_st.rdata = 32'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // synchronous reset leaves the circuits and code lines high, running, monitor item and irq low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, straight from the state register

    assign reg_rdata            = st_ff.rdata;
    assign circuit_n            = st_ff.circuit_n;
    // code line 1 carries the least significant code bit
    assign alarm_code_line1     = st_ff.code_n[0];
    assign alarm_code_line2     = st_ff.code_n[1];
    assign alarm_code_line3     = st_ff.code_n[2];
    assign running_monitor_item = st_ff.running_mon;
    assign status_running       = st_ff.status_run;
    assign irq                  = st_ff.irq;

endmodule

`default_nettype wire

// ### servo_status_pkg.sv
// types shared by the servo status output logic
package servo_status_pkg;
    `include "servo_status_consts.svh"

    // status flags, active high inside the block
    typedef struct packed {
        logic approach;
        logic caution;
        logic ready;
        logic running;
    } flags_s;

    // complete state of the status output block
    typedef struct packed {
        logic [`ROT_W-1:0]         rot_level;
        logic [`APPR_W-1:0]        approach_w;
        logic [`OSEL_W-1:0]        osel1;
        logic [`OSEL_W-1:0]        osel2;
        logic [`OSEL_W-1:0]        osel3;
        logic                      wcode_sel;
        logic                      abs_use;
        flags_s                    int_status;
        flags_s                    int_mask;
        logic [2:0]                req_sync;
        logic                      req_filt;
        flags_s                    flags;
        logic [`NUM_CIRCUITS-1:0]  circuit_n;
        logic [2:0]                code_n;
        logic                      running_mon;
        logic                      status_run;
        logic                      irq;
        logic [31:0]               rdata;
    } state_s;
endpackage

// ### test_servo_status_outputs.sv
// self-checking bench for the servo status outputs
`timescale 1ns/10ps
`default_nettype none
`include "servo_status_consts.svh"
module test_servo_status_outputs;
    logic               core_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic [7:0]         reg_addr = '0;
    logic [31:0]        reg_wdata = '0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic signed [15:0] motor_speed = '0;
    logic signed [31:0] position_error = '0;
    logic               position_mode = 1'b0;
    logic               servo_alarm = 1'b0;
    logic [2:0]         alarm_code = '0;
    logic               main_power_on = 1'b1;
    logic               overload_warn = 1'b0;
    logic               regen_warn = 1'b0;
    logic               abs_transfer_done = 1'b0;
    logic               req_en = 1'b0;
    logic               abs_data_request;
    logic [31:0]        reg_rdata;
    logic [2:0]         circuit_n;
    logic               alarm_code_line1, alarm_code_line2, alarm_code_line3;
    logic               running_monitor_item, status_running, irq;
    int                 lvl = 20, wid = 7, num_errors = 0, checked = 0, cycles = 0;
    logic [15:0]        o1 = 16'h3211, o2 = '0, o3 = '0;
    logic [1:0]         cfg = '0;

    //////////////////////////////
    servo_status_outputs dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_speed(motor_speed), .position_error(position_error),
        .position_mode(position_mode), .servo_alarm(servo_alarm), .alarm_code(alarm_code),
        .main_power_on(main_power_on), .overload_warn(overload_warn), .regen_warn(regen_warn),
        .abs_transfer_done(abs_transfer_done), .abs_data_request(abs_data_request), .circuit_n(circuit_n),
        .alarm_code_line1(alarm_code_line1), .alarm_code_line2(alarm_code_line2),
        .alarm_code_line3(alarm_code_line3), .running_monitor_item(running_monitor_item),
        .status_running(status_running), .irq(irq));
    host_ctrl_model host (.req_en(req_en), .abs_data_request(abs_data_request));

    // clock and hang guard
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    //////////////////////////////
    // expected flags {approach, caution, ready, running}
    function automatic logic [3:0] flg();
        int s = motor_speed;
        int e = position_error;
        flg[0] = (s < 0 ? -s : s) > lvl;
        flg[1] = !servo_alarm && main_power_on && (!cfg[1] || (req_en && abs_transfer_done));
        flg[2] = overload_warn || regen_warn;
        flg[3] = position_mode && (e < 0 ? -e : e) < wid;
    endfunction
    // expected circuits, active low, OR of flags on each
    function automatic logic [2:0] expc();
        logic [3:0]  f = flg();
        logic [15:0] a = {o3[3:0], o2[15:12], o1[15:8]};
        expc = 3'h7;
        for (int i = 0; i < 4; i++)
            for (int c = 1; c <= 3; c++)
                if (f[i] && a[4*i+:4] == c) expc[c-1] = 1'b0;
    endfunction
    // expected {line3, line2, line1}, low is on
    function automatic logic [2:0] expcode();
        if (servo_alarm) return ~alarm_code;
        if (cfg[0] && overload_warn) return 3'h6;
        if (cfg[0] && regen_warn) return 3'h5;
        return 3'h7;
    endfunction
    function automatic logic [3:0] rn();
        return 4'($urandom_range(4));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic set_lvl(input int v);
        wr(`ADDR_ROT_LEVEL, v);
        lvl = v < 1 ? 1 : v > 10000 ? 10000 : v;
        rd(`ADDR_ROT_LEVEL, lvl);
    endtask
    task automatic set_wid(input int v);
        wr(`ADDR_APPROACH_W, v);
        wid = v < 1 ? 1 : v > 250 ? 250 : v;
        rd(`ADDR_APPROACH_W, wid);
    endtask
    // settle, then compare circuits, code lines and running, and read the status and monitor words
    task automatic check_all();
        logic [3:0] f;
        repeat (12) @(posedge core_clk);
        #1 f = flg();
        chk(circuit_n, expc());
        chk({alarm_code_line3, alarm_code_line2, alarm_code_line1}, expcode());
        chk(status_running, f[0]);
        rd(`ADDR_STATUS, {req_en, f});
        rd(`ADDR_MONITOR, f[0]);
    endtask
    task automatic put(input int s, input int e, input logic m);
        @(posedge core_clk);
        motor_speed <= 16'(s);
        position_error <= 32'(e);
        position_mode <= m;
        check_all();
    endtask
    task automatic rand_regs();
        set_lvl($urandom_range(16383));
        set_wid($urandom_range(255));
        o1 = {rn(), rn(), 8'($urandom)};
        o2 = {rn(), 12'($urandom)};
        o3 = {12'($urandom), rn()};
        cfg = 2'($urandom);
        wr(`ADDR_OSEL1, o1);
        wr(`ADDR_OSEL2, o2);
        wr(`ADDR_OSEL3, o3);
        wr(`ADDR_CONFIG, cfg);
        rd(`ADDR_OSEL1, o1);
    endtask
    task automatic rand_inputs();
        int k = $urandom_range(3);
        @(posedge core_clk);
        motor_speed <= k == 0 ? 16'(lvl) : k == 1 ? -16'(lvl + 1) : 16'($urandom);
        position_error <= k == 0 ? 32'(wid) : 32'($urandom_range(600)) - 32'd300;
        position_mode <= 1'($urandom);
        servo_alarm <= $urandom_range(3) == 0;
        main_power_on <= $urandom_range(3) != 0;
        overload_warn <= 1'($urandom);
        regen_warn <= 1'($urandom);
        alarm_code <= 3'($urandom);
        abs_transfer_done <= 1'($urandom);
        req_en <= $urandom_range(3) != 0;
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge core_clk);
        #1 chk(irq, e);
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    //////////////////////////////
    initial begin
        void'($urandom(32));
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk({circuit_n, alarm_code_line3, alarm_code_line2, alarm_code_line1, irq}, 32'h7E);
        rd(`ADDR_ROT_LEVEL, 32'h14);
        rd(`ADDR_APPROACH_W, 32'h7);
        rd(`ADDR_OSEL1, 32'h3211);
        rd(`ADDR_OSEL2, 32'h0);
        rd(`ADDR_OSEL3, 32'h0);
        wr(8'h3C, 32'hFF);
        rd(8'h3C, 32'h0);
        $display("reset test done");
        // thresholds at their edges, approach on circuit 1
        set_lvl(0);
        set_lvl(10001);
        set_wid(251);
        set_lvl(20);
        set_wid(9);
        o3 = 16'h0001;
        wr(`ADDR_OSEL3, o3);
        put(20, 9, 1'b1);
        put(21, 8, 1'b1);
        put(-21, -8, 1'b1);
        put(21, 3, 1'b0);
        // caution allocation codes, sharing circuits
        overload_warn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            o2 = 16'(k << 12);
            wr(`ADDR_OSEL2, o2);
            put(k * 9, 0, 1'b1);
        end
        $display("corner test done");
        for (int n = 0; n < 150; n++) begin
            if (n % 5 == 0) rand_regs();
            rand_inputs();
            check_all();
        end
        $display("random test done");
        // interrupt raised by running, masked and cleared
        set_lvl(20);
        @(posedge core_clk);
        servo_alarm <= 1'b1;
        overload_warn <= 1'b0;
        regen_warn <= 1'b0;
        put(0, 0, 1'b0);
        wr(`ADDR_INT_STATUS, 32'hF);
        wr(`ADDR_INT_MASK, 32'h0);
        chk_irq(1'b0);
        put(21, 0, 1'b0);
        chk(irq, 1'b0);
        rd(`ADDR_INT_STATUS, 32'h1);
        wr(`ADDR_INT_MASK, 32'h1);
        chk_irq(1'b1);
        wr(`ADDR_INT_STATUS, 32'h1);
        wr(`ADDR_INT_MASK, 32'h0);
        chk_irq(1'b0);
        $display("interrupt test done");
        end_sim();
    end
endmodule
`default_nettype wire
